// >>> src/als_consts.svh
// Purpose: Constants of the serial result lane sequencer
// Assumes: Eight channels, sixteen bit slots per result
// Notes: Included by package and design files
`ifndef ALS_CONSTS_SVH
`define ALS_CONSTS_SVH
`define ALS_CHANNELS 8
`define ALS_PAIRS 4
`define ALS_SLOT_BITS 16
`define ALS_SLOT_W 4
`define ALS_CH_W 3
`define ALS_CNT_W 7
`define ALS_FILL_W 4
`define ALS_PAIR_STRIDE 3'h2
`define ALS_FIFO_DEPTH 16
`define ALS_CNT_ZERO 7'h00
`define ALS_CNT_STEP 7'h01
`define ALS_FILL_ZERO 4'h0
`define ALS_FILL_STEP 4'h1
`define ALS_FILL_FULL 4'h8
`endif

// >>> src/als_pkg.sv
// Purpose: Types of the serial result lane sequencer
// Assumes: Constants header on the include path
// Notes: Pins and lanes travel as packed structs
`include "als_consts.svh"
package als_pkg;
  typedef logic [`ALS_SLOT_BITS-1:0] als_word_type;
  typedef struct packed {
    logic convert_strobe;
    logic shift_clock;
    logic data_rate_select;
    logic diff_mode_select;
  } als_pins_type;
  typedef struct packed {
    logic [`ALS_CHANNELS-1:0] result_lane;
    logic [`ALS_PAIRS-1:0] diff_result_pair_p;
    logic [`ALS_PAIRS-1:0] diff_result_pair_n;
    logic echoed_shift_clock;
  } als_lanes_type;
  typedef enum logic [1:0] {
    ST_FILL = 2'b01,
    ST_FULL = 2'b10
  } als_load_state_type;
endpackage

// >>> src/als_fifo.sv
// Purpose: Result word buffer between conversion core and sequencer
// Assumes: Power of two depth
// Notes: Valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module als_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_check
    $error("als_fifo needs a power of two depth of at least two");
  end
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
  logic [AW:0] cnt_reg, cnt_next;
  logic push, pop;

  always_comb begin
    in_ready = cnt_reg != (AW+1)'(DEPTH);
    out_valid = cnt_reg != '0;
    out_data = mem_reg[rd_reg];
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    wr_next = push ? wr_reg + 1'b1 : wr_reg;
    rd_next = pop ? rd_reg + 1'b1 : rd_reg;
    cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      cnt_reg <= cnt_next;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem_reg[wr_reg] <= in_data;
    end
  end
endmodule
`default_nettype wire

// >>> src/als_sequencer.sv
// Purpose: Places eight channel results on serial lanes in circular order
// Assumes: Pins are asynchronous to CLOCK and far slower than it
// Notes: Eight results per conversion arrive through the buffer
`timescale 1ns/1ps
`default_nettype none
`include "als_consts.svh"
module als_sequencer #(
  parameter int FIFO_DEPTH = `ALS_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic SYS_RST,
  // Pins from the host
  input wire als_pkg::als_pins_type PINS,
  // Results from the conversion core
  input wire logic RESULT_VALID,
  output logic RESULT_READY,
  input wire als_pkg::als_word_type RESULT_DATA,
  // Serial lanes to the host
  output als_pkg::als_lanes_type LANES
);
  import als_pkg::*;

  if (FIFO_DEPTH < `ALS_CHANNELS) begin : g_check
    $error("Buffer must hold at least one full frame");
  end

  // Pin synchronisers
  als_pins_type sync1_reg, sync2_reg, prev_reg;
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      prev_reg <= '0;
    end else begin
      sync1_reg <= PINS;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end

  logic cnv_fall, sck_fall, sck_any, shift_adv;
  always_comb begin
    cnv_fall = prev_reg.convert_strobe && !sync2_reg.convert_strobe;
    sck_fall = prev_reg.shift_clock && !sync2_reg.shift_clock;
    sck_any = prev_reg.shift_clock != sync2_reg.shift_clock;
    shift_adv = sync2_reg.data_rate_select ? sck_any : sck_fall;
  end

  // Result buffer
  logic buf_valid, buf_ready;
  als_word_type buf_data;
  als_fifo #(
    .WIDTH(`ALS_SLOT_BITS),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(CLOCK),
    .rst(SYS_RST),
    .in_valid(RESULT_VALID),
    .in_ready(RESULT_READY),
    .in_data(RESULT_DATA),
    .out_valid(buf_valid),
    .out_ready(buf_ready),
    .out_data(buf_data)
  );

  // Frame loader
  als_load_state_type st_reg, st_next;
  logic [`ALS_FILL_W-1:0] fill_reg, fill_next;
  als_word_type stage_reg [`ALS_CHANNELS];
  als_word_type stage_next [`ALS_CHANNELS];
  als_word_type frame_reg [`ALS_CHANNELS];
  als_word_type frame_next [`ALS_CHANNELS];
  logic active_reg, active_next;
  logic [`ALS_CNT_W-1:0] cnt_reg, cnt_next;

  always_comb begin
    st_next = st_reg;
    fill_next = fill_reg;
    stage_next = stage_reg;
    frame_next = frame_reg;
    active_next = active_reg;
    cnt_next = cnt_reg;
    buf_ready = 1'b0;
    unique case (st_reg)
      ST_FILL: begin
        buf_ready = 1'b1;
        if (buf_valid) begin
          stage_next[fill_reg[`ALS_CH_W-1:0]] = buf_data;
          fill_next = fill_reg + `ALS_FILL_STEP;
          if (fill_next == `ALS_FILL_FULL) begin
            st_next = ST_FULL;
          end
        end
      end
      ST_FULL: begin
        if (cnv_fall) begin
          frame_next = stage_reg;
          fill_next = `ALS_FILL_ZERO;
          st_next = ST_FILL;
        end
      end
      default: begin
        st_next = ST_FILL;
        fill_next = `ALS_FILL_ZERO;
      end
    endcase
    if (cnv_fall) begin
      active_next = 1'b1;
      cnt_next = `ALS_CNT_ZERO;
    end else if (active_reg && shift_adv) begin
      cnt_next = cnt_reg + `ALS_CNT_STEP;
    end
  end

  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      st_reg <= ST_FILL;
      fill_reg <= `ALS_FILL_ZERO;
      active_reg <= 1'b0;
      cnt_reg <= `ALS_CNT_ZERO;
      for (int i = 0; i < `ALS_CHANNELS; i++) begin
        stage_reg[i] <= '0;
        frame_reg[i] <= '0;
      end
    end else begin
      st_reg <= st_next;
      fill_reg <= fill_next;
      active_reg <= active_next;
      cnt_reg <= cnt_next;
      stage_reg <= stage_next;
      frame_reg <= frame_next;
    end
  end

  // Lane data
  als_lanes_type lanes_reg, lanes_next;
  logic [`ALS_CH_W-1:0] slot_idx, ch_idx;
  logic [`ALS_SLOT_W-1:0] bit_idx;
  als_word_type frame_cur [`ALS_CHANNELS];
  always_comb begin
    frame_cur = frame_next;
    slot_idx = cnt_next[`ALS_CNT_W-1:`ALS_SLOT_W];
    bit_idx = ~cnt_next[`ALS_SLOT_W-1:0];
    lanes_next = '0;
    ch_idx = '0;
    for (int i = 0; i < `ALS_CHANNELS; i++) begin
      ch_idx = `ALS_CH_W'(i) + slot_idx;
      lanes_next.result_lane[i] = active_next && frame_cur[ch_idx][bit_idx];
    end
    for (int p = 0; p < `ALS_PAIRS; p++) begin
      ch_idx = `ALS_CH_W'(p) * `ALS_PAIR_STRIDE + slot_idx;
      lanes_next.diff_result_pair_p[p] = active_next && frame_cur[ch_idx][bit_idx];
      lanes_next.diff_result_pair_n[p] = sync2_reg.diff_mode_select &&
        !lanes_next.diff_result_pair_p[p];
    end
    lanes_next.echoed_shift_clock = sync2_reg.shift_clock;
  end

  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      lanes_reg <= '0;
    end else begin
      lanes_reg <= lanes_next;
    end
  end

  assign LANES = lanes_reg;
endmodule
`default_nettype wire

// >>> sim/als_sequencer_checker.sv
// Purpose: Port checks of the lane sequencer
// Assumes: Pins slow against CLOCK
// Notes: Bound to the top module
`timescale 1ns/1ps
`default_nettype none
module als_sequencer_checker #(
  parameter int FIFO_DEPTH = 16
) (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic SYS_RST,
  // Watched ports
  input wire als_pkg::als_pins_type PINS,
  input wire logic RESULT_VALID,
  input wire logic RESULT_READY,
  input wire als_pkg::als_word_type RESULT_DATA,
  input wire als_pkg::als_lanes_type LANES
);
  import als_pkg::*;
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (SYS_RST);
  reset_quiet_a: assert property ($fell(SYS_RST) |-> (LANES == '0) [*3])
    else $error("lanes busy after reset");
  pair_match_a: assert property (LANES.diff_result_pair_p ==
    {LANES.result_lane[6], LANES.result_lane[4], LANES.result_lane[2], LANES.result_lane[0]})
    else $error("pair start channel wrong");
  n_inverse_a: assert property (PINS.diff_mode_select [*5] |->
    LANES.diff_result_pair_n == ~LANES.diff_result_pair_p) else $error("pair not inverse");
  n_off_a: assert property (!PINS.diff_mode_select [*5] |-> LANES.diff_result_pair_n == '0)
    else $error("pair low side active");
  echo_rise_a: assert property ($rose(PINS.shift_clock) |->
    ##[2:5] $rose(LANES.echoed_shift_clock)) else $error("echo rise missing");
  echo_fall_a: assert property ($fell(PINS.shift_clock) |->
    ##[2:5] $fell(LANES.echoed_shift_clock)) else $error("echo fall missing");
  echo_still_a: assert property ($stable(PINS.shift_clock) [*6] |->
    $stable(LANES.echoed_shift_clock)) else $error("echo moved alone");
  lane_step_a: assert property ($changed(LANES.result_lane) |->
    $changed(LANES.echoed_shift_clock) || $past(PINS.convert_strobe, 6))
    else $error("lane moved without edge");
  ready_cause_a: assert property ($fell(RESULT_READY) |-> $past(RESULT_VALID))
    else $error("buffer filled without push");
endmodule
bind als_sequencer als_sequencer_checker #(.FIFO_DEPTH(FIFO_DEPTH)) als_sequencer_checker_inst (
  .CLOCK, .SYS_RST, .PINS, .RESULT_VALID, .RESULT_READY, .RESULT_DATA, .LANES);
`default_nettype wire

// >>> sim/als_host_model.sv
// Purpose: Host receiver driving strobe and shift clock
// Assumes: Shift clock still outside frames
// Notes: Captured lanes kept in cap
`timescale 1ns/1ps
`default_nettype none
module als_host_model (
  // Mode and lanes
  input wire logic rate_ddr,
  input wire als_pkg::als_lanes_type lanes,
  // Host pins
  output logic strobe,
  output logic sclk
);
  import als_pkg::*;
  als_lanes_type cap [256];
  initial begin
    strobe = 0;
    sclk = 0;
  end
  task automatic frame(input int nb);
    strobe = 1;
    #41.3;
    strobe = 0;
    #100;
    for (int n = 0; n < nb; n++) begin
      if (!rate_ddr) begin
        sclk = 1;
        #62.5;
      end
      cap[n] = lanes;
      sclk = rate_ddr & ~sclk;
      #62.5;
    end
    sclk = 0;
  endtask
endmodule
`default_nettype wire

// >>> sim/als_sequencer_tb_top.sv
// Purpose: Self-checking bench of the lane sequencer
// Assumes: Host model drives strobe and shift clock
// Notes: Fill to refusal, then six frames
`timescale 1ns/1ps
`default_nettype none
module als_sequencer_tb_top;
  import als_pkg::*;
  logic clock = 0, sys_rst = 1, valid = 0, ddr = 0, diff = 0;
  logic ready, strb, sck;
  als_word_type data = '0;
  als_pins_type pins;
  als_lanes_type lanes;
  als_word_type q[$];
  als_word_type frm [8];
  logic [31:0] seed = 32'heccc;
  int mismatches = 0, checked = 0;
  bit tk;
  assign pins = {strb, sck, ddr, diff};
  always #2 clock = ~clock;
  als_sequencer als_sequencer_inst (.CLOCK(clock), .SYS_RST(sys_rst), .PINS(pins),
    .RESULT_VALID(valid), .RESULT_READY(ready), .RESULT_DATA(data), .LANES(lanes));
  als_host_model als_host_model_inst (.rate_ddr(ddr), .lanes(lanes), .strobe(strb), .sclk(sck));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic als_lanes_type exp_l(int n, logic df, logic d);
    als_lanes_type e;
    int s;
    int b;
    s = (n / 16) % 8;
    b = 15 - n % 16;
    for (int i = 0; i < 8; i++) e.result_lane[i] = frm[(i + s) % 8][b];
    for (int p = 0; p < 4; p++) begin
      e.diff_result_pair_p[p] = frm[(2 * p + s) % 8][b];
      e.diff_result_pair_n[p] = df & ~e.diff_result_pair_p[p];
    end
    e.echoed_shift_clock = d ? n[0] : 1'b1;
    return e;
  endfunction
  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, got, exp);
    end
  endtask
  task automatic push(input als_word_type w);
    @(negedge clock);
    valid = 1;
    data = w;
    tk = ready;
    @(posedge clock);
    if (tk) q.push_back(w);
  endtask
  task automatic run(input int f);
    int nb [6] = '{128, 128, 144, 128, 32, 64};
    @(negedge clock);
    valid = 0;
    ddr = f[0];
    diff = f[1];
    for (int k = 0; k < 8; k++) frm[k] = q.pop_front();
    repeat (30) @(negedge clock);
    als_host_model_inst.frame(nb[f]);
    for (int n = 0; n < nb[f]; n++)
      chk(als_host_model_inst.cap[n], exp_l(n, f[1], f[0]));
  endtask
  task automatic print_verdict();
    $display("mismatches %0d checked %0d", mismatches, checked);
    if (mismatches == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (10) @(negedge clock);
    sys_rst = 0;
    for (int k = 0; k < 30; k++)
      push(k == 0 ? 16'h8000 : k == 1 ? 16'h0001 : als_word_type'(xs()));
    chk(17'(q.size()), 17'h18);
    for (int f = 0; f < 6; f++) begin
      if (f > 2) for (int k = 0; k < 8; k++) push(als_word_type'(xs()));
      run(f);
    end
    @(negedge clock);
    sys_rst = 1;
    q.delete();
    repeat (3) @(negedge clock);
    chk(17'(lanes), 17'h0);
    chk(17'(ready), 17'h1);
    sys_rst = 0;
    @(negedge clock);
    chk(17'(lanes), 17'h0);
    for (int k = 0; k < 8; k++) push(als_word_type'(xs()));
    run(4);
    als_host_model_inst.frame(32);
    for (int n = 0; n < 32; n++)
      chk(als_host_model_inst.cap[n], exp_l(n, 1'b0, 1'b0));
    print_verdict();
  end
  initial begin
    #200000;
    mismatches++;
    print_verdict();
  end
endmodule
`default_nettype wire
